// *** hw/uisc_cfg.svh ***
`ifndef UISC_CFG_SVH
`define UISC_CFG_SVH
// register addresses on the local bus
`define UISC_ADDR_FLAGS    8'h20
`define UISC_ADDR_MASK     8'h21
`define UISC_ADDR_POLARITY 8'h22
`define UISC_ADDR_SYSCTL   8'h23
`define UISC_ADDR_READY    8'h24
// reset values
`define UISC_MASK_RST      8'h01
`define UISC_POL_RST       1'b0
// field positions
`define UISC_POL_INTERRUPT_REQUEST_PIN_BIT  0
`define UISC_SWRST_BIT     0
`define UISC_STOP_HI       7
`define UISC_STOP_LO       4
`define UISC_STOP_CODE     4'ha
// cause bit positions in the flags register
`define UISC_C_SETUP       0
`define UISC_C_ENDPT1      1
`define UISC_C_ENDPT2      2
`define UISC_C_CTRL_RX     3
`define UISC_C_CTRL_TX     4
`define UISC_C_BUSRST      5
`define UISC_C_SUSPEND     6
`define UISC_C_ENDPT3      7
// ready flag register bit of endpoint one transmit
`define UISC_RDY_ENDPT1_TX 5
`endif

// *** hw/uisc_pkg.sv ***
package uisc_pkg;
  typedef enum logic [1:0] {UISC_RUN, UISC_SWRST, UISC_STOPPED} uisc_state_t;
endpackage : uisc_pkg

// *** hw/uisc_irq_standby.sv ***
`timescale 1ns/1ns
`include "uisc_cfg.svh"
module uisc_irq_standby #(
  parameter int DATA_W = 8,                         // register width
  parameter int NCAUSE = 8                          // interrupt causes
) (
  input  wire logic              mclk_in,           // 20 mhz clock
  input  wire logic              reset_n_in,        // async hardware reset
  input  wire logic [7:0]        addr_in,           // register address
  input  wire logic [DATA_W-1:0] wdata_in,          // write data
  input  wire logic              wr_in,             // write strobe, one cycle
  input  wire logic              rd_in,             // read strobe, one cycle
  input  wire logic [NCAUSE-1:0] cause_set_in,      // cause events, one cycle
  input  wire logic [NCAUSE-1:0] cause_clr_in,      // cause cleared by hardware
  input  wire logic              dma_pkt_full_in,   // dma wrote a max size packet
  output logic [DATA_W-1:0]      rdata_out,         // read data
  output logic                   interrupt_request_pin_out, // interrupt pin
  output logic                   osc_stop_out,      // oscillator stopped
  output logic                   sys_reset_out      // internal system reset, one cycle
);

  uisc_pkg::uisc_state_t  state;
  uisc_pkg::uisc_state_t  next_state;
  logic [NCAUSE-1:0]      pend;
  logic [NCAUSE-1:0]      cause_ack;
  logic [NCAUSE-1:0]      interrupt_cause_mask;
  logic [NCAUSE-1:0]      interrupt_cause_flags;
  logic                   pin_polarity_select;
  logic [DATA_W-1:0]      endpoint_ready_flags;
  logic                   soft_rst;
  logic                   any_pend;
  logic                   wr_mask;
  logic                   wr_polarity;
  logic                   wr_sysctl;
  logic                   wr_ready;
  logic                   swrst_req;
  logic                   stop_req;
  logic                   next_pin;
  logic [DATA_W-1:0]      next_rdata;

  // register select, shared by every write decode; the read mux decodes addr_in with its own case
  function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_addr);
    hit = (a == reg_addr);
  endfunction : hit

  // pin level for a request under the chosen polarity
  function automatic logic pin_level(input logic req, input logic pol);
    pin_level = pol ? req : ~req;
  endfunction : pin_level

  // write decode, one strobe per register except the flags register, which has none
  assign wr_mask     = wr_in && hit(addr_in, `UISC_ADDR_MASK);
  assign wr_polarity = wr_in && hit(addr_in, `UISC_ADDR_POLARITY);
  assign wr_sysctl   = wr_in && hit(addr_in, `UISC_ADDR_SYSCTL);
  assign wr_ready    = wr_in && hit(addr_in, `UISC_ADDR_READY);
  assign swrst_req   = wr_sysctl && wdata_in[`UISC_SWRST_BIT];
  assign stop_req    = wr_sysctl && (wdata_in[`UISC_STOP_HI:`UISC_STOP_LO] == `UISC_STOP_CODE);

  // software reset is one internal cycle then behaves like the pin, but leaves rdata_out as it was
  assign soft_rst      = (state == uisc_pkg::UISC_SWRST);
  assign sys_reset_out = soft_rst;
  assign osc_stop_out  = (state == uisc_pkg::UISC_STOPPED);

  // reset bit wins over a stop code carried in the same write
  always_comb
  begin
    next_state = state;
    case (state)
      uisc_pkg::UISC_RUN:
      begin
        if (swrst_req)
          next_state = uisc_pkg::UISC_SWRST;
        else if (stop_req)
          next_state = uisc_pkg::UISC_STOPPED;
      end
      uisc_pkg::UISC_SWRST:
      begin
        next_state = uisc_pkg::UISC_RUN;
      end
      uisc_pkg::UISC_STOPPED:
      begin
        // other codes leave a stopped oscillator stopped
        if (swrst_req)
          next_state = uisc_pkg::UISC_SWRST;
        else
          next_state = uisc_pkg::UISC_STOPPED;
      end
      default:
      begin
        next_state = uisc_pkg::UISC_RUN;
      end
    endcase
  end

  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      state <= uisc_pkg::UISC_RUN;
    end
    else
    begin
      state <= next_state;
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      interrupt_cause_mask <= NCAUSE'(`UISC_MASK_RST);
    end
    else if (soft_rst)
    begin
      interrupt_cause_mask <= NCAUSE'(`UISC_MASK_RST);
    end
    else if (wr_mask)
    begin
      interrupt_cause_mask <= wdata_in[NCAUSE-1:0];
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      pin_polarity_select <= `UISC_POL_RST;
    end
    else if (soft_rst)
    begin
      pin_polarity_select <= `UISC_POL_RST;
    end
    else if (wr_polarity)
    begin
      pin_polarity_select <= wdata_in[`UISC_POL_INTERRUPT_REQUEST_PIN_BIT];
    end
  end

  // ready flags: a written 1 toggles the flag; a full dma packet sets the
  // endpoint one transmit flag and wins over a write in the same cycle
  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      endpoint_ready_flags <= '0;
    end
    else if (soft_rst)
    begin
      endpoint_ready_flags <= '0;
    end
    else
    begin
      if (wr_ready)
      begin
        endpoint_ready_flags <= endpoint_ready_flags ^ wdata_in;
      end
      if (dma_pkt_full_in)
      begin
        endpoint_ready_flags[`UISC_RDY_ENDPT1_TX] <= 1'b1;
      end
    end
  end

  // pending causes; set wins over an ack or hardware clear in the same cycle, soft reset wins over set. a cause stays
  // pending while masked, so restoring the mask raises the pin again
  genvar g;
  generate
    for (g = 0; g < NCAUSE; g++)
    begin : g_cause
      assign cause_ack[g] = wr_ready && wdata_in[g];
      always_ff @(posedge mclk_in or negedge reset_n_in)
      begin
        if (!reset_n_in)
        begin
          pend[g] <= 1'b0;
        end
        else if (soft_rst)
        begin
          pend[g] <= 1'b0;
        end
        else if (cause_set_in[g] && interrupt_cause_mask[g])
        begin
          pend[g] <= 1'b1;
        end
        else if (cause_ack[g] || cause_clr_in[g])
        begin
          pend[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // masking is combinational so a cleared enable drops the flag at once
  assign interrupt_cause_flags = pend & interrupt_cause_mask;
  assign any_pend              = |interrupt_cause_flags;

  always_comb
  begin
    next_pin = pin_level(any_pend, pin_polarity_select);
  end

  // level output: extra causes while pending give no new edge
  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      interrupt_request_pin_out <= 1'b1;
    end
    else if (soft_rst)
    begin
      interrupt_request_pin_out <= 1'b1;
    end
    else
    begin
      interrupt_request_pin_out <= next_pin;
    end
  end

  // unmapped addresses read as zero
  always_comb
  begin
    next_rdata = '0;
    case (addr_in)
      `UISC_ADDR_FLAGS:
      begin
        next_rdata = DATA_W'(interrupt_cause_flags);
      end
      `UISC_ADDR_MASK:
      begin
        next_rdata = DATA_W'(interrupt_cause_mask);
      end
      `UISC_ADDR_POLARITY:
      begin
        next_rdata = DATA_W'(pin_polarity_select);
      end
      `UISC_ADDR_READY:
      begin
        next_rdata = endpoint_ready_flags;
      end
      default:
      begin
        next_rdata = '0;
      end
    endcase
  end

  // read data holds until the next read strobe
  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      rdata_out <= '0;
    end
    else if (rd_in)
    begin
      rdata_out <= next_rdata;
    end
  end

endmodule : uisc_irq_standby

// *** bench/uisc_irq_standby_monitor.sv ***
`timescale 1ns/1ns
`include "uisc_cfg.svh"
module uisc_mon #(parameter int DATA_W = 8, parameter int NCAUSE = 8) (
  input logic mclk_in,                   // clock
  input logic reset_n_in,                // reset
  input logic [7:0] addr_in,             // address
  input logic [DATA_W-1:0] wdata_in,     // data
  input logic wr_in,                     // write
  input logic rd_in,                     // read
  input logic [NCAUSE-1:0] cause_set_in, // events
  input logic [NCAUSE-1:0] cause_clr_in, // clears
  input logic [DATA_W-1:0] rdata_out,    // read data
  input logic interrupt_request_pin_out, // pin
  input logic osc_stop_out,              // stopped
  input logic sys_reset_out              // soft reset
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);
  wire logic sc = wr_in && addr_in == `UISC_ADDR_SYSCTL;
  wire logic rf = rd_in && addr_in == `UISC_ADDR_FLAGS;
  logic pol;
  // polarity is no port, so it is shadowed from the writes
  always_ff @(posedge mclk_in or negedge reset_n_in)
    if (!reset_n_in) pol <= 1'b0;
    else if (sys_reset_out) pol <= 1'b0;
    else if (wr_in && addr_in == `UISC_ADDR_POLARITY) pol <= wdata_in[0];
  sequence s_setup;
    sys_reset_out ##1 cause_set_in[0] && !wr_in ##1 !wr_in;
  endsequence
  a_srst_pulse: assert property (sc && wdata_in[0] |=> sys_reset_out) else $error("no srst");
  a_stop_enter: assert property (sc && wdata_in[7:4] == 4'ha && !wdata_in[0] && !sys_reset_out |=> osc_stop_out)
    else $error("no stop");
  a_stop_hold: assert property (osc_stop_out && !(sc && wdata_in[0]) |=> osc_stop_out) else $error("stop left");
  a_srst_state: assert property (sys_reset_out |=> !osc_stop_out && interrupt_request_pin_out) else $error("srst");
  a_setup_on: assert property (s_setup |=> !interrupt_request_pin_out) else $error("setup off");
  a_pin_steady: assert property (($stable(cause_set_in) && cause_set_in != 0 && !wr_in && cause_clr_in == 0
    && !sys_reset_out)[*3] |=> $stable(interrupt_request_pin_out)) else $error("pin moved");
  a_mask_zero: assert property (wr_in && addr_in == `UISC_ADDR_MASK && wdata_in == 0 ##2 rf |=> rdata_out == 0)
    else $error("masked flag");
  a_pin_level: assert property (rf |=> sys_reset_out
    || ((rdata_out != 0) == (interrupt_request_pin_out == $past(pol)))) else $error("pin level");
endmodule : uisc_mon
bind uisc_irq_standby uisc_mon #(.DATA_W(DATA_W), .NCAUSE(NCAUSE)) u_mon (.mclk_in, .reset_n_in, .addr_in,
  .wdata_in, .wr_in, .rd_in, .cause_set_in, .cause_clr_in, .rdata_out, .interrupt_request_pin_out,
  .osc_stop_out, .sys_reset_out);

// *** bench/uisc_dma_model.sv ***
`timescale 1ns/1ns
module uisc_dma_model (
  input logic mclk_in,      // clock
  input logic reset_n_in,   // reset
  input logic start_in,     // packet begins
  input logic [3:0] len_in, // fill time
  output logic full_out     // full packet written
);
  logic [3:0] cnt;
  always_ff @(posedge mclk_in or negedge reset_n_in)
    if (!reset_n_in) cnt <= 4'h0;
    else if (start_in) cnt <= len_in;
    else if (cnt != 4'h0) cnt <= cnt - 4'h1;
  assign full_out = cnt == 4'h1;
endmodule : uisc_dma_model

// *** bench/uisc_irq_standby_test.sv ***
`timescale 1ns/1ns
`include "uisc_cfg.svh"
module uisc_irq_standby_test;
  logic mclk_in = 0, reset_n_in = 0, wr_in = 0, rd_in = 0, st = 0, p;
  logic [7:0] addr_in = 0, wdata_in = 0, cause_set_in = 0, cause_clr_in = 0, rdata_out, r, m, s;
  logic [3:0] n = 1;
  logic interrupt_request_pin_out, osc_stop_out, sys_reset_out, dma_pkt_full_in;
  int num_errors = 0, n_tests = 0, cyc = 0;
  uisc_irq_standby dut (.mclk_in, .reset_n_in, .addr_in, .wdata_in, .wr_in, .rd_in, .cause_set_in, .cause_clr_in,
    .dma_pkt_full_in, .rdata_out, .interrupt_request_pin_out, .osc_stop_out, .sys_reset_out);
  uisc_dma_model dma (.mclk_in, .reset_n_in, .start_in(st), .len_in(n), .full_out(dma_pkt_full_in));
  initial forever #25 mclk_in = ~mclk_in;
  function automatic logic [7:0] pin_of(logic [7:0] f, logic q);
    return {7'h0, (f != 8'h00) ~^ q};
  endfunction : pin_of
  task automatic chk(logic [7:0] g, e);
    n_tests++;
    if (g !== e)
    begin
      num_errors++;
      $display("MISMATCH %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(logic [7:0] a, v);
    @(posedge mclk_in) {wr_in, addr_in, wdata_in} <= {1'b1, a, v};
    @(posedge mclk_in) wr_in <= 1'b0;
  endtask : wr
  task automatic rd(logic [7:0] a);
    @(posedge mclk_in) {rd_in, addr_in} <= {1'b1, a};
    @(posedge mclk_in) rd_in <= 1'b0;
    @(negedge mclk_in) r = rdata_out;
  endtask : rd
  task automatic ev(logic [7:0] v);
    @(posedge mclk_in) cause_set_in <= v;
    repeat (4) @(posedge mclk_in);
    cause_set_in <= 8'h00;
    @(negedge mclk_in);
  endtask : ev
  task automatic report_and_stop;
    $display("errors %0d of %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  always @(posedge mclk_in)
    if (++cyc == 3000)
    begin
      num_errors++;
      report_and_stop();
    end
  initial
  begin
    void'($urandom(63840));
    repeat (5) @(posedge mclk_in);
    reset_n_in <= 1'b1;
    rd(`UISC_ADDR_MASK);
    chk(8'(interrupt_request_pin_out), 8'h01);
    chk(r, `UISC_MASK_RST);
    for (int i = 0; i < 8; i++)
    begin
      m = (i == 0) ? 8'h00 : 8'($urandom) | 8'(1 << i);
      s = 8'($urandom) | 8'(1 << i);
      p = 1'($urandom);
      wr(`UISC_ADDR_POLARITY, {7'h0, p});
      wr(`UISC_ADDR_MASK, m);
      ev(s);
      rd(`UISC_ADDR_FLAGS);
      chk(r, s & m);
      chk(8'(interrupt_request_pin_out), pin_of(s & m, p));
      @(posedge mclk_in) cause_clr_in <= 8'hff;
      @(posedge mclk_in) cause_clr_in <= 8'h00;
    end
    wr(`UISC_ADDR_MASK, 8'h02);
    ev(8'h02);
    wr(`UISC_ADDR_READY, 8'h02);
    rd(`UISC_ADDR_FLAGS);
    chk({r[7:1], interrupt_request_pin_out}, pin_of(8'h00, p));
    ev(8'h02);
    wr(`UISC_ADDR_MASK, 8'h00);
    rd(`UISC_ADDR_FLAGS);
    chk({r[7:1], interrupt_request_pin_out}, pin_of(8'h00, p));
    wr(`UISC_ADDR_MASK, 8'h02);
    rd(`UISC_ADDR_FLAGS);
    chk(r, 8'h02);
    chk(8'(interrupt_request_pin_out), pin_of(8'h02, p));
    wr(`UISC_ADDR_SYSCTL, 8'ha0);
    wr(`UISC_ADDR_SYSCTL, 8'h50);
    @(negedge mclk_in) chk(8'(osc_stop_out), 8'h01);
    wr(`UISC_ADDR_SYSCTL, 8'h01);
    ev(8'h01);
    chk({osc_stop_out, interrupt_request_pin_out}, 8'h00);
    rd(`UISC_ADDR_MASK);
    chk(r, `UISC_MASK_RST);
    wr(`UISC_ADDR_SYSCTL, 8'ha0);
    @(posedge mclk_in) reset_n_in <= 1'b0;
    @(posedge mclk_in) reset_n_in <= 1'b1;
    @(negedge mclk_in) chk(8'(osc_stop_out), 8'h00);
    wr(`UISC_ADDR_READY, 8'h20);
    rd(`UISC_ADDR_READY);
    chk(r & 8'h20, 8'h20);
    wr(`UISC_ADDR_READY, 8'h20);
    rd(`UISC_ADDR_READY);
    chk(r & 8'h20, 8'h00);
    @(posedge mclk_in) {st, n} <= {1'b1, 4'($urandom_range(15, 1))};
    @(posedge mclk_in) st <= 1'b0;
    @(posedge dma_pkt_full_in);
    rd(`UISC_ADDR_READY);
    chk(r & 8'h20, 8'h20);
    report_and_stop();
  end
endmodule : uisc_irq_standby_test
